// ---- rtl/ptw_timer_pair.sv ----
// Notes on behaviour
// - Wide mode: lower run starts/stops pair
// - Narrow mode: lower run drives lower only
// - Halt-in-idle stops counting during idle
// - Gate ignored when external clock selected
// - Prescale codes divide by 1,8,64,256
// - Wide bit set joins timers
// - Wide bit clear: two separate timers
// - Upper control ignored in wide mode
// - External source counts lower pin rising edges
// - Internal source is oscillator divided two
// - Control write while running clears prescaler
// - Upper timer uses own fields narrow mode
// - Upper external source uses upper pin
// - Unimplemented control bits read zero
// - Upper count holds most significant word
// - Upper period holds most significant word
// - Wide interrupt flagged on upper flag
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "ptw_map.svh"
module ptw_timer_pair
    import ptw_pkg::*;
(
    input  wire logic        ref_clk,          // Oscillator clock
    input  wire logic        rst_n,            // Synchronous reset
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB enable
    input  wire logic        pwrite,           // APB direction
    input  wire logic [11:0] paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic      [31:0] prdata,           // APB read data
    output logic             pready,           // APB ready
    output logic             pslverr,          // APB error
    input  wire logic        idle_mode,        // Device in idle
    input  wire logic        lower_ext_clock_pin, // Lower external clock
    input  wire logic        upper_ext_clock_pin, // Upper external clock
    input  wire logic        lower_gate_pin,   // Lower gate input
    input  wire logic        upper_gate_pin,   // Upper gate input
    output logic             irq               // Interrupt level
);
    ////////////////////////////////////////////////////////////////////////
    logic [15:0] lo_ctrl_q;
    logic [15:0] hi_ctrl_q;
    logic [15:0] lo_cnt_q;
    logic [15:0] hi_cnt_q;
    logic [15:0] lo_cnt_d;
    logic [15:0] hi_cnt_d;
    logic [15:0] lo_per_q;
    logic [15:0] hi_per_q;
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic [1:0]  stat_d;
    logic [7:0]  lo_ps_q;
    logic [7:0]  hi_ps_q;
    logic        pclk_q;
    logic [1:0]  eclk_q;
    logic [1:0]  gate_q;
    logic        rdy_q;
    logic        err_q;
    logic        irq_q;
    logic [31:0] rdata_q;

    ptw_ctrl_type lc, hc;
    assign lc = '{run: lo_ctrl_q[`PTW_BIT_RUN], halt: lo_ctrl_q[`PTW_BIT_HALT],
                  gate: lo_ctrl_q[`PTW_BIT_GATE], ps: lo_ctrl_q[`PTW_BIT_PS_HI:`PTW_BIT_PS_LO],
                  wide: lo_ctrl_q[`PTW_BIT_WIDE], cs: lo_ctrl_q[`PTW_BIT_CS]};
    assign hc = '{run: hi_ctrl_q[`PTW_BIT_RUN], halt: hi_ctrl_q[`PTW_BIT_HALT],
                  gate: hi_ctrl_q[`PTW_BIT_GATE], ps: hi_ctrl_q[`PTW_BIT_PS_HI:`PTW_BIT_PS_LO],
                  wide: 1'b0, cs: hi_ctrl_q[`PTW_BIT_CS]};

    ////////////////////////////////////////////////////////////////////////
    // APB decode, single wait state so reads see settled counters
    wire access   = psel && penable && !rdy_q;
    wire wr       = access && pwrite;
    wire hit_lc   = paddr == `PTW_OFF_LO_CTRL;
    wire hit_hc   = paddr == `PTW_OFF_HI_CTRL;
    wire hit_lcnt = paddr == `PTW_OFF_LO_COUNT;
    wire hit_hcnt = paddr == `PTW_OFF_HI_COUNT;
    wire hit_lper = paddr == `PTW_OFF_LO_PERIOD;
    wire hit_hper = paddr == `PTW_OFF_HI_PERIOD;
    wire hit_stat = paddr == `PTW_OFF_IRQ_STAT;
    wire hit_mask = paddr == `PTW_OFF_IRQ_MASK;
    wire hit_mode = paddr == `PTW_OFF_MODE;
    wire mapped   = hit_lc | hit_hc | hit_lcnt | hit_hcnt | hit_lper | hit_hper
                  | hit_stat | hit_mask | hit_mode;
    wire wr_lc    = wr && hit_lc;
    wire wr_hc    = wr && hit_hc;

    logic [31:0] rd_mux;
    assign rd_mux = hit_lc   ? {16'h0000, lo_ctrl_q} :
                    hit_hc   ? {16'h0000, hi_ctrl_q} :
                    hit_lcnt ? {16'h0000, lo_cnt_q}  :
                    hit_hcnt ? {16'h0000, hi_cnt_q}  :
                    hit_lper ? {16'h0000, lo_per_q}  :
                    hit_hper ? {16'h0000, hi_per_q}  :
                    hit_stat ? {30'h00000000, stat_q} :
                    hit_mask ? {30'h00000000, mask_q} :
                    hit_mode ? {31'h00000000, lc.wide} : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Peripheral clock enable at half the oscillator rate
    wire pclk_en = pclk_q;

    // Upper controls take effect only in narrow mode
    wire wide     = lc.wide;
    wire hi_run   = !wide && hc.run;
    wire lo_idle  = lc.halt && idle_mode;
    wire hi_idle  = hc.halt && idle_mode;

    // Rising edges of external clock pins; one register delay
    wire lo_erise = lower_ext_clock_pin && !eclk_q[0];
    wire hi_erise = upper_ext_clock_pin && !eclk_q[1];
    wire lo_gfall = !lower_gate_pin && gate_q[0];
    wire hi_gfall = !upper_gate_pin && gate_q[1];

    // Gating honoured only with the internal clock
    wire lo_gate_on = lc.gate && !lc.cs;
    wire hi_gate_on = hc.gate && !hc.cs;
    wire lo_src = lc.cs ? lo_erise : (pclk_en && (!lo_gate_on || lower_gate_pin));
    wire hi_src = hc.cs ? hi_erise : (pclk_en && (!hi_gate_on || upper_gate_pin));

    function automatic logic [7:0] ps_term(input logic [1:0] code);
        unique case (code)
            2'b00: ps_term = `PTW_PS_DIV1;
            2'b01: ps_term = `PTW_PS_DIV8;
            2'b10: ps_term = `PTW_PS_DIV64;
            2'b11: ps_term = `PTW_PS_DIV256;
        endcase
    endfunction : ps_term

    wire lo_active = lc.run && !lo_idle;
    wire hi_active = hi_run && !hi_idle;
    wire lo_tick   = lo_active && lo_src && (lo_ps_q == ps_term(lc.ps));
    wire hi_tick   = hi_active && hi_src && (hi_ps_q == ps_term(hc.ps));

    // Wide counter and period compare
    wire [31:0] w_cnt = {hi_cnt_q, lo_cnt_q};
    wire [31:0] w_per = {hi_per_q, lo_per_q};
    wire        w_match = w_cnt == w_per;
    wire        lo_match = lo_cnt_q == lo_per_q;
    wire        hi_match = hi_cnt_q == hi_per_q;
    wire [31:0] w_next = w_match ? 32'h00000000 : w_cnt + 32'h00000001;

    always_comb begin
        lo_cnt_d = lo_cnt_q;
        hi_cnt_d = hi_cnt_q;
        if (wide) begin
            if (lo_tick) begin
                lo_cnt_d = w_next[15:0];
                hi_cnt_d = w_next[31:16];
            end
        end else begin
            if (lo_tick) begin
                lo_cnt_d = lo_match ? 16'h0000 : lo_cnt_q + 16'h0001;
            end
            if (hi_tick) begin
                hi_cnt_d = hi_match ? 16'h0000 : hi_cnt_q + 16'h0001;
            end
        end
        if (wr && hit_lcnt) begin
            lo_cnt_d = pwdata[15:0];
        end
        if (wr && hit_hcnt) begin
            hi_cnt_d = pwdata[15:0];
        end
    end

    // Event bits: [0] lower, [1] upper; wide mode raises upper only
    logic       lo_per_evt;
    logic       lo_gate_evt;
    logic       w_per_evt;
    logic       hi_per_evt;
    logic       hi_gate_evt;
    logic       lo_evt;
    logic       hi_evt;
    logic [1:0] clr;
    assign lo_per_evt  = lo_tick && lo_match;
    assign lo_gate_evt = lo_gate_on && lo_gfall;
    assign w_per_evt   = lo_tick && w_match;
    assign hi_per_evt  = hi_tick && hi_match;
    assign hi_gate_evt = hi_gate_on && hi_gfall;
    assign lo_evt      = !wide && lc.run && (lo_per_evt || lo_gate_evt);
    assign hi_evt      = wide ? (lc.run && (w_per_evt || lo_gate_evt))
                              : (hc.run && (hi_per_evt || hi_gate_evt));
    assign clr         = (wr && hit_stat) ? pwdata[1:0] : 2'b00;
    // Set wins over a simultaneous clear
    assign stat_d      = (stat_q & ~clr) | {hi_evt, lo_evt};

    ////////////////////////////////////////////////////////////////////////
    // Next values kept apart so the flop processes stay trivial
    logic [15:0] lo_ctrl_d;
    logic [15:0] hi_ctrl_d;
    logic [15:0] lo_per_d;
    logic [15:0] hi_per_d;
    logic [1:0]  mask_d;
    logic        irq_d;
    logic        pclk_d;
    logic [31:0] rdata_d;
    logic        err_d;
    assign lo_ctrl_d = wr_lc ? (pwdata[15:0] & `PTW_LO_CTRL_MASK) : lo_ctrl_q;
    assign hi_ctrl_d = wr_hc ? (pwdata[15:0] & `PTW_HI_CTRL_MASK) : hi_ctrl_q;
    assign lo_per_d  = (wr && hit_lper) ? pwdata[15:0] : lo_per_q;
    assign hi_per_d  = (wr && hit_hper) ? pwdata[15:0] : hi_per_q;
    assign mask_d    = (wr && hit_mask) ? pwdata[1:0] : mask_q;
    assign irq_d     = |(stat_d & mask_q);
    assign pclk_d    = pclk_q ^ `PTW_PCLK_DIV;
    assign rdata_d   = (access && !pwrite) ? rd_mux : 32'h00000000;
    assign err_d     = access && !mapped;

    // Half-rate enable for the internal source
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pclk_q <= 1'b0;
        end else begin
            pclk_q <= pclk_d;
        end
    end

    // Pin history; reset value equals the idle low level, so no false edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            eclk_q <= 2'b00;
        end else begin
            eclk_q <= {upper_ext_clock_pin, lower_ext_clock_pin};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            gate_q <= 2'b00;
        end else begin
            gate_q <= {upper_gate_pin, lower_gate_pin};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lo_ctrl_q <= `PTW_CTRL_RST;
        end else begin
            lo_ctrl_q <= lo_ctrl_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hi_ctrl_q <= `PTW_CTRL_RST;
        end else begin
            hi_ctrl_q <= hi_ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Prescaler restarts on any control write while running, and while stopped
    logic       lo_ps_end;
    logic       hi_ps_end;
    logic       lo_ps_clr;
    logic       hi_ps_clr;
    logic [7:0] lo_ps_d;
    logic [7:0] hi_ps_d;
    assign lo_ps_end = lo_ps_q == ps_term(lc.ps);
    assign hi_ps_end = hi_ps_q == ps_term(hc.ps);
    assign lo_ps_clr = (wr_lc && lc.run) || !lc.run;
    assign hi_ps_clr = (wr_hc && hc.run) || !hi_run;
    assign lo_ps_d   = lo_ps_end ? 8'h00 : lo_ps_q + 8'h01;
    assign hi_ps_d   = hi_ps_end ? 8'h00 : hi_ps_q + 8'h01;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || lo_ps_clr) begin
            lo_ps_q <= 8'h00;
        end else if (lo_active && lo_src) begin
            lo_ps_q <= lo_ps_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || hi_ps_clr) begin
            hi_ps_q <= 8'h00;
        end else if (hi_active && hi_src) begin
            hi_ps_q <= hi_ps_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counters and period registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lo_cnt_q <= 16'h0000;
        end else begin
            lo_cnt_q <= lo_cnt_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hi_cnt_q <= 16'h0000;
        end else begin
            hi_cnt_q <= hi_cnt_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            lo_per_q <= `PTW_PERIOD_RST;
        end else begin
            lo_per_q <= lo_per_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hi_per_q <= `PTW_PERIOD_RST;
        end else begin
            hi_per_q <= hi_per_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags; set priority lives in stat_d
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            stat_q <= 2'b00;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mask_q <= 2'b00;
        end else begin
            mask_q <= mask_d;
        end
    end

    // Fed from stat_d, so the plain flop on the interrupt pin adds no lag behind the flags
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus response after one wait state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= access;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else begin
            err_q <= err_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Outputs straight from their flops
    assign prdata  = rdata_q;
    assign pready  = rdy_q;
    assign pslverr = err_q;
    assign irq     = irq_q;
endmodule : ptw_timer_pair

// ---- rtl/ptw_map.svh ----
`ifndef PTW_MAP_SVH
`define PTW_MAP_SVH
// Register byte offsets
`define PTW_OFF_LO_CTRL   12'h000
`define PTW_OFF_HI_CTRL   12'h004
`define PTW_OFF_LO_COUNT  12'h008
`define PTW_OFF_HI_COUNT  12'h00C
`define PTW_OFF_LO_PERIOD 12'h010
`define PTW_OFF_HI_PERIOD 12'h014
`define PTW_OFF_IRQ_STAT  12'h018
`define PTW_OFF_IRQ_MASK  12'h01C
`define PTW_OFF_MODE      12'h020
// Control field positions
`define PTW_BIT_RUN   15
`define PTW_BIT_HALT  13
`define PTW_BIT_GATE  6
`define PTW_BIT_PS_HI 5
`define PTW_BIT_PS_LO 4
`define PTW_BIT_WIDE  3
`define PTW_BIT_CS    1
// Writable masks, reset values
`define PTW_LO_CTRL_MASK 16'hA07A
`define PTW_HI_CTRL_MASK 16'hA072
`define PTW_CTRL_RST     16'h0000
`define PTW_PERIOD_RST   16'hFFFF
// Prescale terminal counts (divide minus one)
`define PTW_PS_DIV1   8'h00
`define PTW_PS_DIV8   8'h07
`define PTW_PS_DIV64  8'h3F
`define PTW_PS_DIV256 8'hFF
// Oscillator to peripheral clock divider (Fosc/2)
`define PTW_PCLK_DIV  1'b1
`endif

// ---- rtl/ptw_pkg.sv ----
package ptw_pkg;
    typedef struct packed {
        logic       run;
        logic       halt;
        logic       gate;
        logic [1:0] ps;
        logic       wide;
        logic       cs;
    } ptw_ctrl_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ptw_apb_req_type;
endpackage : ptw_pkg

// ---- tb/ptw_pins_model.sv ----
`timescale 1ns/100ps
module ptw_pins_model (
    input  wire logic ref_clk, // Clock
    input  wire logic go_lo,   // Lower train on
    input  wire logic go_hi,   // Upper train on
    input  wire logic gate_lo, // Lower gate level
    input  wire logic gate_hi, // Upper gate level
    output logic      lo_ck,   // Lower ext clock
    output logic      hi_ck,   // Upper ext clock
    output logic      lo_gate, // Lower gate pin
    output logic      hi_gate  // Upper gate pin
);
    logic [1:0] lo_q = 2'h0;
    logic [1:0] hi_q = 2'h0;
    // Restart per frame so pins rest low between frames
    always @(posedge ref_clk) begin
        lo_q <= go_lo ? lo_q + 2'h1 : 2'h0;
        hi_q <= go_hi ? hi_q + 2'h1 : 2'h0;
    end
    assign lo_ck   = lo_q[1];
    assign hi_ck   = hi_q[1];
    assign lo_gate = gate_lo;
    assign hi_gate = gate_hi;
endmodule : ptw_pins_model

// ---- tb/ptw_timer_pair_asserts.sv ----
`timescale 1ns/100ps
module ptw_timer_pair_asserts (
    input wire logic        ref_clk, // Clock
    input wire logic        rst_n,   // Reset
    input wire logic        psel,    // Select
    input wire logic        penable, // Enable
    input wire logic        pwrite,  // Direction
    input wire logic [11:0] paddr,   // Address
    input wire logic [31:0] prdata,  // Read data
    input wire logic        pready,  // Ready
    input wire logic        pslverr  // Error
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire rd_ok = pready && !pwrite;
    sequence s_take; psel && penable && !pready; endsequence
    sequence s_done; pready ##1 !pready; endsequence
    property p_answer; s_take |=> s_done; endproperty
    property p_lo_zero; rd_ok && paddr == 12'h000 |-> (prdata & ~32'h0000A07A) == 32'h0; endproperty
    property p_hi_zero; rd_ok && paddr == 12'h004 |-> (prdata & ~32'h0000A072) == 32'h0; endproperty
    property p_cnt; rd_ok && (paddr == 12'h008 || paddr == 12'h00C) |-> prdata[31:16] == 16'h0; endproperty
    property p_per; rd_ok && (paddr == 12'h010 || paddr == 12'h014) |-> prdata[31:16] == 16'h0; endproperty
    property p_mode; rd_ok && paddr == 12'h020 |-> prdata[31:1] == 31'h0; endproperty
    property p_unmap; pready && paddr > 12'h020 |-> pslverr && prdata == 32'h0; endproperty
    property p_map; pready && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_answer: assert property (p_answer) else $error("bad ready");
    a_lo_zero: assert property (p_lo_zero) else $error("lower ctrl spare bit");
    a_hi_zero: assert property (p_hi_zero) else $error("upper ctrl spare bit");
    a_cnt: assert property (p_cnt) else $error("count width");
    a_per: assert property (p_per) else $error("period width");
    a_mode: assert property (p_mode) else $error("mode width");
    a_unmap: assert property (p_unmap) else $error("no error");
    a_map: assert property (p_map) else $error("stray error");
endmodule : ptw_timer_pair_asserts
////////////////////////////////////////
bind ptw_timer_pair ptw_timer_pair_asserts chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// ---- tb/ptw_timer_pair_tb.sv ----
`timescale 1ns/100ps
module ptw_timer_pair_tb;
    import ptw_pkg::*;
    ptw_apb_req_type req = '0;
    logic        ref_clk = 0;
    logic        rst_n = 0;
    logic        idle_mode = 0;
    logic        go_l = 0, go_h = 0, gl = 0, gh = 0;
    logic        pready, pslverr, irq, lck, uck, lg, ug, err;
    logic [31:0] prdata, rd, a, b;
    int          err_total = 0, check_count = 0, cyc = 0, t1, t2;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    ptw_timer_pair dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(req.psel), .penable(req.penable),
        .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_mode(idle_mode), .lower_ext_clock_pin(lck), .upper_ext_clock_pin(uck),
        .lower_gate_pin(lg), .upper_gate_pin(ug), .irq(irq));
    ptw_pins_model pins_u (.ref_clk(ref_clk), .go_lo(go_l), .go_hi(go_h), .gate_lo(gl), .gate_hi(gh),
        .lo_ck(lck), .hi_ck(uck), .lo_gate(lg), .hi_gate(ug));
    ////////////////////////////////////////
    task automatic summarize;
        $display("mismatches %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n = 0;
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, w, ad, wd};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        req <= '0;
        if (n >= 20) begin
            err_total++;
            summarize();
        end
    endtask : apb
    task automatic wirq(output int t);
        int n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (irq !== 1'b1 && n < 5000);
        if (n >= 5000) begin
            err_total++;
            summarize();
        end
        t = cyc;
    endtask : wirq
    // Interval between two events, in clock cycles
    task automatic meas(input logic [15:0] ctl, input int exp);
        apb(1, 12'h000, {16'h0, ctl});
        apb(1, 12'h018, 3);
        wirq(t1);
        apb(1, 12'h018, 3);
        wirq(t1);
        apb(1, 12'h018, 3);
        wirq(t2);
        chk(t2 - t1, exp);
    endtask : meas
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        apb(1, 12'h000, 32'hFFFF);
        apb(0, 12'h000, 0);
        chk(rd, 32'hA07A);
        apb(1, 12'h000, 0);
        apb(1, 12'h004, 32'hFFFF);
        apb(0, 12'h004, 0);
        chk(rd, 32'hA072);
        apb(1, 12'h004, 0);
        apb(0, 12'h040, 0);
        chk({err, rd[30:0]}, 32'h80000000);
        for (int h = 0; h < 2; h++) begin
            idle_mode <= 1'b1;
            apb(1, 12'h000, 32'h8000 | (h << 13));
            apb(0, 12'h008, 0);
            a = rd;
            repeat (20) @(posedge ref_clk);
            apb(0, 12'h008, 0);
            chk(rd == a, h);
        end
        apb(1, 12'h000, 0);
        idle_mode <= 1'b0;
        apb(1, 12'h010, 7);
        apb(1, 12'h008, 0);
        apb(0, 12'h010, 0);
        chk(rd, 7);
        apb(1, 12'h01C, 1);
        for (int k = 0; k < 4; k++) meas(16'h8000 | (k << 4), 16 * (k == 3 ? 256 : 1 << (3 * k)));
        apb(1, 12'h000, 0);
        apb(1, 12'h018, 1);
        @(negedge ref_clk);
        chk(irq, 0);
        // Upper set to run at 1:256 first; wide mode must ignore it
        apb(1, 12'h014, 0);
        apb(1, 12'h000, 16'h0008);
        apb(1, 12'h004, 16'h8030);
        apb(1, 12'h000, 16'h8008);
        apb(1, 12'h018, 3);
        repeat (40) @(posedge ref_clk);
        apb(0, 12'h018, 0);
        chk(rd, 2);
        @(negedge ref_clk);
        chk(irq, 0);
        apb(0, 12'h020, 0);
        chk(rd, 1);
        apb(1, 12'h01C, 2);
        meas(16'h8008, 16);
        apb(1, 12'h000, 0);
        apb(1, 12'h004, 0);
        apb(1, 12'h010, 32'hFFFF);
        apb(1, 12'h014, 32'hFFFF);
        apb(0, 12'h008, 0);
        a = rd;
        apb(0, 12'h00C, 0);
        b = rd;
        apb(1, 12'h000, 16'h8042);
        apb(1, 12'h004, 16'h8002);
        go_l <= 1'b1;
        go_h <= 1'b1;
        repeat (16) @(posedge ref_clk);
        go_l <= 1'b0;
        go_h <= 1'b0;
        repeat (4) @(posedge ref_clk);
        apb(0, 12'h008, 0);
        chk(rd - a, 4);
        apb(0, 12'h00C, 0);
        chk(rd - b, 4);
        apb(1, 12'h000, 0);
        apb(1, 12'h004, 0);
        apb(1, 12'h018, 3);
        apb(1, 12'h000, 16'h8040);
        apb(0, 12'h008, 0);
        a = rd;
        repeat (20) @(posedge ref_clk);
        apb(0, 12'h008, 0);
        chk(rd, a);
        gl <= 1'b1;
        repeat (20) @(posedge ref_clk);
        gl <= 1'b0;
        repeat (4) @(posedge ref_clk);
        apb(0, 12'h018, 0);
        chk(rd, 1);
        apb(0, 12'h008, 0);
        chk(rd !== a, 1);
        apb(0, 12'h00C, 0);
        chk(rd, b + 4);
        apb(1, 12'h000, 0);
        apb(1, 12'h008, 0);
        apb(1, 12'h000, 16'h8030);
        for (int r = 0; r < 3; r++) begin
            repeat (300) @(posedge ref_clk);
            apb(1, 12'h000, 16'h8030);
        end
        apb(0, 12'h008, 0);
        chk(rd, 0);
        summarize();
    end
endmodule : ptw_timer_pair_tb
